//--- hw/sfm_mapper.sv
// Protective function I/O mapper with brake outputs, error reactions and APB registers.
//
// Overview of operation
// - Positions are scaled to 4096 increments per revolution.
// - Clockwise motion counts positive, counter-clockwise negative.
// - Internal error starts controlled stop on every axis.
// - Fatal error cuts torque on all axes and cannot be cleared.
// - Internal and fatal errors are global; other errors carry their axis.
// - Trigger input bit 0 activates a function, 1 deactivates it.
// - Each mapped input bit is sampled once per operating cycle.
// - Feedback is 1 only when active and safe, except stop feedback and brake test feedback during inspection.
// - A deactivated function holds its feedback at 0, except a stop function, whose feedback follows torque-off.
// - Torque-off and startup states force feedback to 0, except for stop functions and brake test functions during inspection.
// - Stop feedback reads 1 while torque-off is active.
// - Brake test feedback stays 1 during the whole inspection while its trigger input bit is 0.
// - Shared bit is 0 when any active contributor reports 0.
// - Shared bit ignores deactivated contributors.
// - Active controlled stop deactivates the other functions of its axis.
// - Brake output 0 engages the brake, 1 releases it.
// - Two brake outputs, both poles always switched together.
// - Switched-on brake outputs get short off-test pulses.
// - Switched-off brake outputs get short on-test pulses.
// - Open circuit on a brake output raises an error reaction; the code checks only switched-on outputs outside test pulses.
// - One safe control bit in, one safe status bit out per function.
// - Inputs latched at cycle start; outputs handed back at cycle end.
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module sfm_mapper import sfm_pkg::*; #(
   parameter int unsigned CYCLE_LEN = CYCLE_CYC,
   parameter int unsigned TEST_PERIOD = TPER_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Safe fieldbus process data
   input wire logic [NBIT-1:0] function_trigger_in,
   output logic [NBIT-1:0] safe_status_out,
   output logic cycle_done,
   // Monitoring and drive side
   input wire logic [NFUNC-1:0] fn_safe,
   input wire sfm_err_t err_evt,
   input wire logic [NAXIS-1:0] axis_standstill,
   input wire logic brake_inspecting,
   input wire logic [NAXIS-1:0] enc_step,
   input wire logic [NAXIS-1:0] enc_up,
   output logic [NAXIS-1:0] stop_req,
   output logic [NAXIS-1:0] torque_cutoff,
   // Brake outputs, high and low side switch
   output logic [1:0] brake_output_a,
   output logic [1:0] brake_output_b,
   input wire logic [NAXIS-1:0] brake_current
);
   logic [4:0] ctrl_q;
   logic [5:0] err_q;
   logic [31:0] scale_q [NAXIS];
   logic [31:0] raw_q [NAXIS];
   logic [31:0] pos_q [NAXIS];
   sfm_fcfg_t fcfg_q [NFUNC];
   sfm_state_t state_q;
   logic [NBIT-1:0] in_q;
   logic [31:0] cyc_cnt_q;
   logic tick;
   logic [31:0] tp_cnt_q, plen_q;
   logic pulse;
   logic [NAXIS-1:0] stop_q, cut_q, brk_q, cmd;
   logic [1:0] ond_q [NFUNC];
   logic [NFUNC-1:0] trig, eff, fb;
   logic [NAXIS-1:0] stop_act;
   logic [NBIT-1:0] map_d;
   logic wr, rd_ok;
   logic [31:0] rd_d;
   logic [5:0] err_set, err_clr;

   assign wr = psel & penable & pready & pwrite;

   // Operating cycle divider.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc_cnt_q <= 32'h0;
      end else if (cyc_cnt_q == CYCLE_LEN - 1) begin
         cyc_cnt_q <= 32'h0;
      end else begin
         cyc_cnt_q <= cyc_cnt_q + 32'h1;
      end
   end
   assign tick = (cyc_cnt_q == CYCLE_LEN - 1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_q <= '1;
         safe_status_out <= '0;
         cycle_done <= 1'b0;
      end else begin
         cycle_done <= tick;
         if (tick) begin
            in_q <= function_trigger_in;
            safe_status_out <= map_d;
         end
      end
   end

   // Stop requests per axis feed back into the per-function view.
   always_comb begin
      stop_act = '0;
      for (int i = 0; i < NFUNC; i++) begin
         if (fcfg_q[i].kind == K_STOP && trig[i]) begin
            stop_act[fcfg_q[i].axis] = 1'b1;
         end
      end
   end

   // Per function activation and feedback.
   for (genvar i = 0; i < NFUNC; i++) begin : g_fn
      assign trig[i] = fcfg_q[i].en & ~in_q[fcfg_q[i].in_idx];
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            ond_q[i] <= 2'h0;
         end else if (tick) begin
            if (!trig[i]) begin
               ond_q[i] <= 2'h0;
            end else if (ond_q[i] != 2'(ONDELAY_CYCLES)) begin
               ond_q[i] <= ond_q[i] + 2'h1;
            end
         end
      end
      assign eff[i] = trig[i] & (ond_q[i] == 2'(ONDELAY_CYCLES)) &
         !(stop_act[fcfg_q[i].axis] && fcfg_q[i].kind != K_STOP);
      always_comb begin
         fb[i] = eff[i] & fn_safe[i];
         if (state_q != ST_RUN) begin
            fb[i] = 1'b0;
         end
         if (fcfg_q[i].kind == K_STOP) begin
            fb[i] = cut_q[fcfg_q[i].axis];
         end
         if (fcfg_q[i].kind == K_BTEST && trig[i] && brake_inspecting) begin
            fb[i] = 1'b1;
         end
      end
   end

   // Status bit mapping, single or shared.
   for (genvar b = 0; b < NBIT; b++) begin : g_bit
      always_comb begin
         logic [3:0] nmap;
         logic all_ok, single;
         nmap = 4'h0;
         all_ok = 1'b1;
         single = 1'b0;
         for (int i = 0; i < NFUNC; i++) begin
            if (fcfg_q[i].en && fcfg_q[i].out_idx == 5'(b)) begin
               nmap = nmap + 4'h1;
               single = fb[i];
               if (eff[i] && !fb[i]) begin
                  all_ok = 1'b0;
               end
            end
         end
         if (nmap == 4'h0) begin
            map_d[b] = 1'b0;
         end else if (nmap == 4'h1) begin
            map_d[b] = single;
         end else begin
            map_d[b] = all_ok;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_q <= '0;
         cut_q <= '0;
      end else begin
         for (int a = 0; a < NAXIS; a++) begin
            stop_q[a] <= stop_act[a] | err_q[ERR_INT] | err_q[ERR_AX + a] |
               err_q[ERR_OC + a];
            cut_q[a] <= err_q[ERR_FATAL] | (stop_q[a] & axis_standstill[a]);
         end
      end
   end
   assign stop_req = stop_q;
   assign torque_cutoff = cut_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_STARTUP;
      end else begin
         unique case (state_q)
            ST_STARTUP: begin
               if (ctrl_q[CTRL_RUN] && !err_q[ERR_FATAL]) begin
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (&cut_q) begin
                  state_q <= ST_TORQUE_OFF;
               end
            end
            ST_TORQUE_OFF: begin
               if (!(|cut_q)) begin
                  state_q <= ST_RUN;
               end
            end
            default: state_q <= ST_STARTUP;
         endcase
      end
   end

   // Brake test pulse timing.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tp_cnt_q <= 32'h0;
         plen_q <= 32'h0;
      end else begin
         tp_cnt_q <= (tp_cnt_q == TEST_PERIOD - 1) ? 32'h0 : tp_cnt_q + 32'h1;
         plen_q <= pulse ? plen_q + 32'h1 : 32'h0;
      end
   end
   assign pulse = (tp_cnt_q < TPULSE_CYC);

   assign cmd = ctrl_q[CTRL_BRK +: NAXIS] & ~cut_q & {NAXIS{state_q == ST_RUN}};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brk_q <= '0;
      end else begin
         brk_q <= cmd ^ {NAXIS{pulse}};
      end
   end
   assign brake_output_a = {2{brk_q[0]}};
   assign brake_output_b = {2{brk_q[1]}};

   // Error flags; a new event wins over a clear in the same cycle.
   always_comb begin
      err_set = {brk_q & ~brake_current & cmd & {NAXIS{!pulse}}, err_evt.axis,
         err_evt.fatal, err_evt.internal};
      err_clr = '0;
      if (wr && paddr == ERR_OFS) begin
         err_clr = pwdata[5:0];
      end
      err_clr[ERR_FATAL] = 1'b0;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_q <= '0;
      end else begin
         err_q <= (err_q & ~err_clr) | err_set;
      end
   end

   for (genvar a = 0; a < NAXIS; a++) begin : g_ax
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            raw_q[a] <= 32'h0;
            pos_q[a] <= 32'h0;
         end else begin
            if (enc_step[a]) begin
               raw_q[a] <= (enc_up[a] ^ ctrl_q[CTRL_INV + a]) ? raw_q[a] + 32'h1 :
                  raw_q[a] - 32'h1;
            end
            pos_q[a] <= 32'(($signed({{32{raw_q[a][31]}}, raw_q[a]}) *
               $signed({32'h0, scale_q[a]})) >>> 16);
         end
      end
   end

   // Configuration writes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RST;
         for (int a = 0; a < NAXIS; a++) begin
            scale_q[a] <= SCALE_RST;
         end
         for (int i = 0; i < NFUNC; i++) begin
            fcfg_q[i] <= '0;
         end
      end else if (wr) begin
         if (paddr == CTRL_OFS) begin
            ctrl_q <= pwdata[4:0];
         end
         for (int a = 0; a < NAXIS; a++) begin
            if (paddr == SCALE0_OFS + 8'(4 * a)) begin
               scale_q[a] <= pwdata;
            end
         end
         for (int i = 0; i < NFUNC; i++) begin
            if (paddr == FCFG0_OFS + 8'(4 * i)) begin
               fcfg_q[i] <= sfm_fcfg_t'(pwdata[$bits(sfm_fcfg_t)-1:0]);
            end
         end
      end
   end

   // Read decode; unmapped offsets answer with an error and zero data.
   always_comb begin
      rd_d = 32'h0;
      rd_ok = 1'b1;
      if (paddr == CTRL_OFS) begin
         rd_d = {27'h0, ctrl_q};
      end else if (paddr == STAT_OFS) begin
         rd_d = {26'h0, cut_q, stop_q, state_q};
      end else if (paddr == ERR_OFS) begin
         rd_d = {26'h0, err_q};
      end else if (paddr == SCALE0_OFS || paddr == SCALE0_OFS + 8'h04) begin
         rd_d = scale_q[~paddr[2]];
      end else if (paddr == POS0_OFS || paddr == POS0_OFS + 8'h04) begin
         rd_d = pos_q[~paddr[2]];
      end else if (paddr[7:5] == 3'h1 && paddr[1:0] == 2'h0) begin
         rd_d = {{(32 - $bits(sfm_fcfg_t)){1'b0}}, fcfg_q[paddr[4:2]]};
      end else begin
         rd_ok = 1'b0;
      end
   end

   // One wait state: the answer comes in the second access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
         prdata <= (psel & penable & ~pready & ~pwrite) ? rd_d : 32'h0;
         pslverr <= psel & penable & ~pready & ~rd_ok;
      end
   end

   sequence s_tick;
      tick;
   endsequence
   a_input_latch: assert property (@(posedge pclk) disable iff (!presetn)
      s_tick |=> (in_q == $past(function_trigger_in)))
      else $error("Inputs not latched at cycle start.");
   a_input_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !tick |=> $stable(in_q))
      else $error("Inputs changed inside a cycle.");
   a_fatal_cut: assert property (@(posedge pclk) disable iff (!presetn)
      err_q[ERR_FATAL] |-> ##2 (&cut_q) and err_q[ERR_FATAL])
      else $error("Fatal error did not cut torque.");
   a_internal_stop: assert property (@(posedge pclk) disable iff (!presetn)
      err_q[ERR_INT] |=> (&stop_q))
      else $error("Internal error did not stop all axes.");
   a_status_forced: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q != ST_RUN && fcfg_q[0].kind == K_GENERIC) |-> !fb[0])
      else $error("Feedback not forced to zero.");
   a_brake_off: assert property (@(posedge pclk) disable iff (!presetn)
      (cut_q[0] && !pulse) |=> !brk_q[0])
      else $error("Brake released under torque cutoff.");
   a_pulse_len: assert property (@(posedge pclk) disable iff (!presetn)
      (!pulse && $past(pulse)) |-> (plen_q == TPULSE_CYC))
      else $error("Test pulse length wrong.");
   a_oc_flag: assert property (@(posedge pclk) disable iff (!presetn)
      (brk_q[0] && cmd[0] && !pulse && !brake_current[0]) |=> err_q[ERR_OC])
      else $error("Open circuit not flagged.");
   a_inactive_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (!trig[0] && fcfg_q[0].kind == K_GENERIC) |-> !fb[0])
      else $error("Inactive function reports one.");
endmodule // sfm_mapper
`default_nettype wire

//--- inc/sfm_pkg.sv
// Package for the protective function I/O mapper: register map, layouts, timing.
package sfm_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   // Operating cycle and brake test timing, in their own units.
   localparam int unsigned CYCLE_US = 1000;
   localparam int unsigned CYCLE_CYC = CYCLE_US * (CLK_HZ / 1_000_000);
   localparam int unsigned TPER_US = 10000;
   localparam int unsigned TPER_CYC = TPER_US * (CLK_HZ / 1_000_000);
   localparam int unsigned TPULSE_NS = 1000;
   localparam int unsigned TPULSE_CYC = (TPULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned ONDELAY_CYCLES = 2;
   localparam int unsigned INC_PER_REV = 4096;
   localparam int unsigned NFUNC = 8;
   localparam int unsigned NAXIS = 2;
   localparam int unsigned NBIT = 32;
   // Register byte offsets.
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] ERR_OFS = 8'h08;
   localparam logic [7:0] SCALE0_OFS = 8'h0c;
   localparam logic [7:0] POS0_OFS = 8'h14;
   localparam logic [7:0] FCFG0_OFS = 8'h20;
   // Reset values.
   localparam logic [31:0] SCALE_RST = 32'h0001_0000;
   localparam logic [4:0] CTRL_RST = 5'h00;
   // Control field positions.
   localparam int unsigned CTRL_RUN = 0;
   localparam int unsigned CTRL_BRK = 1;
   localparam int unsigned CTRL_INV = 3;
   // Error field positions; the fatal bit cannot be cleared.
   localparam int unsigned ERR_INT = 0;
   localparam int unsigned ERR_FATAL = 1;
   localparam int unsigned ERR_AX = 2;
   localparam int unsigned ERR_OC = 4;
   typedef enum logic [1:0] {
      K_GENERIC = 2'h0, K_STOP = 2'h1, K_BTEST = 2'h2
   } sfm_kind_t;
   typedef enum logic [1:0] {
      ST_STARTUP = 2'h0, ST_RUN = 2'h1, ST_TORQUE_OFF = 2'h3
   } sfm_state_t;
   // Per protective function configuration word.
   typedef struct packed {
      logic en;
      sfm_kind_t kind;
      logic axis;
      logic [4:0] out_idx;
      logic [4:0] in_idx;
   } sfm_fcfg_t;
   // Events from the monitoring and drive side.
   typedef struct packed {
      logic internal;
      logic fatal;
      logic [NAXIS-1:0] axis;
   } sfm_err_t;
endpackage

//--- testbench/sfm_ctrl_model.sv
// Safety controller model that drives trigger bits and collects status bits.
`timescale 1ns/100ps
`default_nettype none
module sfm_ctrl_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Requests from the bench, active high
   input wire logic [31:0] req,
   // Safe process data
   input wire logic cycle_done,
   input wire logic [31:0] safe_status_out,
   output logic [31:0] function_trigger_in,
   output logic [31:0] status_seen
);
   // active low, per cycle.
   // New bits follow a finished cycle only, so a tick never sees a half-made update.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         function_trigger_in <= 32'hffff_ffff;
         status_seen <= 32'h0000_0000;
      end else if (cycle_done) begin
         function_trigger_in <= ~req;
         status_seen <= safe_status_out;
      end
   end
endmodule // sfm_ctrl_model
`default_nettype wire

//--- testbench/tb_safety_function_io_mapper.sv
// Self-checking bench for the protective function I/O mapper.
`timescale 1ns/100ps
`default_nettype none
module tb_safety_function_io_mapper;
   import sfm_pkg::*;
   // Short counts keep the run brief; expectations follow from them.
   localparam int unsigned CL = 50;
   localparam int unsigned TP = 200;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, cycle_done, brake_inspecting;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, safe_status_out, trig, req, seen, rd;
   logic [NFUNC-1:0] fn_safe;
   sfm_err_t err_evt;
   logic [NAXIS-1:0] axis_standstill, enc_step, enc_up, stop_req, torque_cutoff, brake_current;
   logic [1:0] brake_output_a, brake_output_b;
   int n_errors, comparisons, cyc;

   sfm_mapper #(.CYCLE_LEN(CL), .TEST_PERIOD(TP)) sfm_mapper_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .function_trigger_in(trig), .safe_status_out(safe_status_out), .cycle_done(cycle_done),
      .fn_safe(fn_safe), .err_evt(err_evt), .axis_standstill(axis_standstill),
      .brake_inspecting(brake_inspecting), .enc_step(enc_step), .enc_up(enc_up),
      .stop_req(stop_req), .torque_cutoff(torque_cutoff), .brake_output_a(brake_output_a),
      .brake_output_b(brake_output_b), .brake_current(brake_current)
   );
   sfm_ctrl_model sfm_ctrl_model_inst (
      .pclk(pclk), .presetn(presetn), .req(req), .cycle_done(cycle_done),
      .safe_status_out(safe_status_out), .function_trigger_in(trig), .status_seen(seen)
   );

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task automatic complete_run;
      $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // A hang costs a mismatch and ends the run at once.
   always @(posedge pclk) begin
      cyc = cyc + 1;
      if (cyc == 10000) begin
         n_errors = n_errors + 1;
         complete_run;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge pclk);
         while (cycle_done !== 1'b1) @(posedge pclk);
      end
      // One more edge so the model's copy of the status has settled.
      @(posedge pclk);
   endtask

   task automatic pulse_err(input sfm_err_t e);
      @(posedge pclk);
      err_evt <= e;
      @(posedge pclk);
      err_evt <= 4'h0;
      repeat (4) @(posedge pclk);
   endtask

   function automatic logic [31:0] cfg(input sfm_kind_t k, input logic ax,
                                       input logic [4:0] o, input logic [4:0] i);
      sfm_fcfg_t c;
      c = '{en: 1'b1, kind: k, axis: ax, out_idx: o, in_idx: i};
      return 32'(c);
   endfunction

   task automatic t_reset;
      apb(1'b0, CTRL_OFS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, SCALE0_OFS, 32'h0);
      chk(rd, SCALE_RST);
      apb(1'b0, 8'hfc, 32'h0);
      chk({31'h0, perr}, 32'h1);
      chk(rd, 32'h0);
   endtask

   task automatic t_pos;
      apb(1'b1, SCALE0_OFS, 32'h0002_0000);
      apb(1'b0, SCALE0_OFS, 32'h0);
      chk(rd, 32'h0002_0000);
      enc_up <= 2'h1;
      enc_step <= 2'h1;
      repeat (3) @(posedge pclk);
      enc_up <= 2'h0;
      repeat (5) @(posedge pclk);
      enc_step <= 2'h0;
      apb(1'b0, POS0_OFS, 32'h0);
      chk(rd, 32'hffff_fffc);
   endtask

   task automatic t_map;
      apb(1'b1, FCFG0_OFS, cfg(K_GENERIC, 1'h0, 5'h0, 5'h0));
      apb(1'b1, CTRL_OFS, 32'h1);
      ticks(4);
      chk(safe_status_out, 32'h0);
      req <= 32'h1;
      ticks(5);
      chk(seen, 32'h1);
      fn_safe <= 8'hfe;
      ticks(4);
      chk(safe_status_out, 32'h0);
      fn_safe <= 8'hff;
   endtask

   task automatic t_shared;
      apb(1'b1, FCFG0_OFS + 8'h04, cfg(K_GENERIC, 1'h0, 5'h1, 5'h1));
      apb(1'b1, FCFG0_OFS + 8'h08, cfg(K_GENERIC, 1'h1, 5'h1, 5'h2));
      fn_safe <= 8'hfb;
      req <= 32'h3;
      ticks(5);
      chk(safe_status_out[1], 32'h1);
      req <= 32'h7;
      ticks(5);
      chk(safe_status_out[1], 32'h0);
      req <= 32'h1;
      ticks(5);
      chk(safe_status_out[1], 32'h1);
      fn_safe <= 8'hff;
   endtask

   task automatic t_brake;
      int lo_a, hi_b, split;
      lo_a = 0;
      hi_b = 0;
      split = 0;
      apb(1'b1, CTRL_OFS, 32'h3);
      repeat (5) @(posedge pclk);
      repeat (TP) begin
         @(posedge pclk);
         lo_a += int'(brake_output_a == 2'b00);
         hi_b += int'(brake_output_b == 2'b11);
         split += int'(^brake_output_a) + int'(^brake_output_b);
      end
      chk(32'(lo_a), TPULSE_CYC);
      chk(32'(hi_b), TPULSE_CYC);
      chk(32'(split), 32'h0);
      brake_current <= 2'b10;
      repeat (TP + 50) @(posedge pclk);
      apb(1'b0, ERR_OFS, 32'h0);
      chk(rd[ERR_OC], 32'h1);
      brake_current <= 2'b11;
      apb(1'b1, ERR_OFS, 32'h30);
   endtask

   task automatic t_err;
      pulse_err(4'h8);
      chk(stop_req, 32'h3);
      apb(1'b0, ERR_OFS, 32'h0);
      chk(rd[3:0], 32'h1);
      pulse_err(4'h1);
      apb(1'b0, ERR_OFS, 32'h0);
      chk(rd[3:2], 32'h1);
   endtask

   task automatic t_fatal;
      apb(1'b1, FCFG0_OFS + 8'h0c, cfg(K_STOP, 1'h1, 5'h3, 5'h3));
      req <= 32'h9;
      ticks(4);
      pulse_err(4'h4);
      chk(torque_cutoff, 32'h3);
      apb(1'b1, ERR_OFS, 32'h2);
      apb(1'b0, ERR_OFS, 32'h0);
      chk(rd[ERR_FATAL], 32'h1);
      apb(1'b0, STAT_OFS, 32'h0);
      chk(rd[1:0], 32'(ST_TORQUE_OFF));
      ticks(4);
      chk(safe_status_out[0], 32'h0);
      chk(safe_status_out[3], 32'h1);
   endtask

   initial begin
      n_errors = 0;
      comparisons = 0;
      cyc = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      req = 32'h0;
      fn_safe = 8'hff;
      err_evt = 4'h0;
      axis_standstill = 2'h3;
      brake_inspecting = 1'b0;
      enc_step = 2'h0;
      enc_up = 2'h0;
      brake_current = 2'b11;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_pos;
      t_map;
      t_shared;
      t_brake;
      t_err;
      t_fatal;
      complete_run;
   end
endmodule // tb_safety_function_io_mapper
`default_nettype wire
